//--- src/wear_pkg.sv
/*
  Shared constants and state type of the breaker wear monitor.
  Assumes a 100 MHz clock and an APB master with 32-bit data.
*/
package wear_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAMP_RES_MS = 1;
  localparam int STAMP_CYCLES = STAMP_RES_MS * 1000000 / CLK_PERIOD_NS;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_OPS1 = 8'h08;
  localparam logic [7:0] OFS_OPS2 = 8'h0c;
  localparam logic [7:0] OFS_NOMINAL_BREAK_CURRENT = 8'h10;
  localparam logic [7:0] OFS_MAX_BREAK_CURRENT = 8'h14;
  localparam logic [7:0] OFS_SET1 = 8'h18;
  localparam logic [7:0] OFS_SET2 = 8'h1c;
  localparam logic [7:0] OFS_COND = 8'h20;
  localparam logic [7:0] OFS_BRKCNT = 8'h24;
  localparam logic [7:0] OFS_A1CNT = 8'h28;
  localparam logic [7:0] OFS_A2CNT = 8'h2c;
  localparam logic [7:0] OFS_LEFT1 = 8'h30;
  localparam logic [7:0] OFS_LEFT2 = 8'h34;
  localparam logic [7:0] OFS_LEFT3 = 8'h38;
  localparam logic [7:0] OFS_INTSTAT = 8'h3c;
  localparam logic [7:0] OFS_INTMASK = 8'h40;
  // ==========================================================
  // fields and defaults
  localparam int CTRL_A1EN = 0;
  localparam int CTRL_A2EN = 1;
  localparam int CTRL_FEN = 2;
  localparam int CTRL_FVAL = 3;
  localparam int CTRL_TSEL = 8;
  localparam int CMD_CLRCNT = 0;
  localparam int CMD_RELOAD = 1;
  localparam logic [17:0] OPS1_DEF = 18'h0_c350;
  localparam logic [17:0] OPS2_DEF = 18'h0_0064;
  localparam logic [13:0] NOMINAL_BREAK_CURRENT_DEF = 14'h0064;
  localparam logic [13:0] MAX_BREAK_CURRENT_DEF = 14'h07d0;
  localparam logic [17:0] SET1_DEF = 18'h0_03e8;
  localparam logic [17:0] SET2_DEF = 18'h0_0064;
  localparam logic [5:0] DIV_BITS = 6'h20;
  // status codes and event codes (also interrupt bit positions)
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_A1 = 2'h1;
  localparam logic [1:0] COND_A2 = 2'h2;
  localparam int EV_TRIG = 0;
  localparam int EV_A1ON = 1;
  localparam int EV_A1OFF = 2;
  localparam int EV_A2ON = 3;
  localparam int EV_A2OFF = 4;
  localparam int EV_NUM = 5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_DIV = 2'b10,
    ST_APPLY = 2'b11
  } calc_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic a1En;
    logic a2En;
    logic forceEn;
    logic [1:0] forceVal;
    logic [2:0] trigSel;
    logic [17:0] ops1;
    logic [17:0] ops2;
    logic [13:0] nominal_break_current;
    logic [13:0] max_break_current;
    logic [17:0] set1;
    logic [17:0] set2;
    logic [2:0][17:0] left;
    logic [31:0] brkCnt;
    logic [31:0] a1Cnt;
    logic [31:0] a2Cnt;
    logic [EV_NUM-1:0] intStat;
    logic [EV_NUM-1:0] intMask;
    logic [EV_NUM-1:0] evtPend;
    logic alarm1;
    logic alarm2;
    logic irq;
    logic trigPrev;
    logic [2:0][13:0] cur;
    logic [1:0] phase;
    calc_type st;
    logic [31:0] quo;
    logic [32:0] rem;
    logic [31:0] den;
    logic [5:0] bitCnt;
    logic evtValid;
    logic [2:0] evtCode;
    logic [31:0] evtStamp;
    logic [16:0] msPre;
    logic [31:0] msCnt;
  } state_type;
endpackage : wear_pkg

//--- src/breaker_wear_monitor.sv
/*
  Breaker wear monitor: APB registers, wear deduction per phase,
  two alarm stages, counters, time-stamped events and interrupt.
  Assumes relay outputs and RMS currents come from same-clock logic.
*/
// Register access over APB and the address map were decided locally.
// Summary of operation
// - capture all three phase currents on each breaker open command that arrives while idle
// - per phase, derive consumed operations and subtract from remaining total
// - each alarm threshold shared by phases; alarm when any count below it
// - a setting selects which relay output acts as the open trigger
// - alarm on and off events go out with a 1 ms time stamp
// - clearable counters of open operations and of both alarm activations
// - each phase's remaining operations is readable
// - wear uses the RMS currents of phases one to three, 5 ms refresh
// - force setting drives status normal, alarm 1 or alarm 2 when forcing on
// - two operating points, defaults 50 000 and 100 operations
// - currents in 0.01 kA steps, defaults 1 kA and 20 kA
// - alarm 1 enable defaults off, threshold default 1 000
// - alarm 2 enable defaults off, threshold default 100
// - settings change only by a direct register write
`timescale 1ns/100ps
`default_nettype none
module breaker_wear_monitor #(
  parameter int MS_CYCLES = wear_pkg::STAMP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [7:0] relayOutputs,
  input wire logic [13:0] phase_one_rms_current,
  input wire logic [13:0] phase_two_rms_current,
  input wire logic [13:0] phase_three_rms_current,
  output logic alarm1,
  output logic alarm2,
  output logic irq,
  output logic evtValid,
  output logic [2:0] evtCode,
  output logic [31:0] evtStamp
);
  wear_pkg::state_type s_ff;
  wear_pkg::state_type nxt_s;

  logic done;
  logic trig;
  logic below1;
  logic below2;
  logic rawA1;
  logic rawA2;
  logic [13:0] ic;
  logic [31:0] num;
  logic [32:0] shifted;
  logic [31:0] deduct;
  logic [31:0] rdata;
  logic hit;
  localparam int EV_BITS = wear_pkg::EV_NUM;
  logic [EV_BITS-1:0] evNew;

  // ==========================================================
  // combinational helpers
  always_comb
  begin
    trig = relayOutputs[s_ff.trigSel];
    below1 = 1'b0;
    below2 = 1'b0;
    for (int p = 0; p < 3; p++)
    begin
      below1 = below1 | (s_ff.left[p] < s_ff.set1);
      below2 = below2 | (s_ff.left[p] < s_ff.set2);
    end
    // forcing overrides the comparators entirely
    if (s_ff.forceEn)
    begin
      rawA1 = s_ff.forceVal == wear_pkg::COND_A1;
      rawA2 = s_ff.forceVal == wear_pkg::COND_A2;
    end
    else
    begin
      rawA1 = s_ff.a1En & below1;
      rawA2 = s_ff.a2En & below2;
    end
    // current clamped into the characteristic's range
    ic = s_ff.cur[s_ff.phase];
    if (ic < s_ff.nominal_break_current)
      ic = s_ff.nominal_break_current;
    if (ic > s_ff.max_break_current)
      ic = s_ff.max_break_current;
    // operands widened first so the product cannot wrap at operand width
    num = (s_ff.ops1 > s_ff.ops2)
          ? {18'h0_0000, ic - s_ff.nominal_break_current} * {14'h0000, s_ff.ops1 - s_ff.ops2}
          : 32'h0000_0000;
    shifted = {s_ff.rem[31:0], s_ff.quo[31]};
    deduct = s_ff.quo + 32'h0000_0001;
    done = psel & penable & s_ff.pready;
  end

  // ==========================================================
  // register read mux
  always_comb
  begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      wear_pkg::OFS_CTRL: rdata = 32'({s_ff.trigSel, 3'h0, s_ff.forceVal, s_ff.forceEn,
                                       s_ff.a2En, s_ff.a1En});
      wear_pkg::OFS_CMD: rdata = 32'h0000_0000;
      wear_pkg::OFS_OPS1: rdata = 32'(s_ff.ops1);
      wear_pkg::OFS_OPS2: rdata = 32'(s_ff.ops2);
      wear_pkg::OFS_NOMINAL_BREAK_CURRENT: rdata = 32'(s_ff.nominal_break_current);
      wear_pkg::OFS_MAX_BREAK_CURRENT: rdata = 32'(s_ff.max_break_current);
      wear_pkg::OFS_SET1: rdata = 32'(s_ff.set1);
      wear_pkg::OFS_SET2: rdata = 32'(s_ff.set2);
      wear_pkg::OFS_COND: rdata = 32'({s_ff.st != wear_pkg::ST_IDLE,
                                       s_ff.alarm2 ? wear_pkg::COND_A2 :
                                       s_ff.alarm1 ? wear_pkg::COND_A1 : wear_pkg::COND_NORMAL});
      wear_pkg::OFS_BRKCNT: rdata = s_ff.brkCnt;
      wear_pkg::OFS_A1CNT: rdata = s_ff.a1Cnt;
      wear_pkg::OFS_A2CNT: rdata = s_ff.a2Cnt;
      wear_pkg::OFS_LEFT1: rdata = 32'(s_ff.left[0]);
      wear_pkg::OFS_LEFT2: rdata = 32'(s_ff.left[1]);
      wear_pkg::OFS_LEFT3: rdata = 32'(s_ff.left[2]);
      wear_pkg::OFS_INTSTAT: rdata = 32'(s_ff.intStat);
      wear_pkg::OFS_INTMASK: rdata = 32'(s_ff.intMask);
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_s = s_ff;
    evNew = '0;
    nxt_s.evtValid = 1'b0;
    // apb: answer one cycle into the access phase
    nxt_s.pready = psel & penable & ~s_ff.pready;
    if (psel & penable & ~s_ff.pready)
    begin
      nxt_s.prdata = pwrite ? 32'h0000_0000 : rdata;
      nxt_s.pslverr = ~hit;
    end
    // only a bus write reaches the settings; no group switching exists
    if (done & pwrite)
    begin
      unique case (paddr)
        wear_pkg::OFS_CTRL:
        begin
          nxt_s.a1En = pwdata[wear_pkg::CTRL_A1EN];
          nxt_s.a2En = pwdata[wear_pkg::CTRL_A2EN];
          nxt_s.forceEn = pwdata[wear_pkg::CTRL_FEN];
          nxt_s.forceVal = pwdata[wear_pkg::CTRL_FVAL +: 2];
          nxt_s.trigSel = pwdata[wear_pkg::CTRL_TSEL +: 3];
        end
        wear_pkg::OFS_CMD:
        begin
          if (pwdata[wear_pkg::CMD_CLRCNT])
          begin
            nxt_s.brkCnt = '0;
            nxt_s.a1Cnt = '0;
            nxt_s.a2Cnt = '0;
          end
          if (pwdata[wear_pkg::CMD_RELOAD])
            nxt_s.left = {3{s_ff.ops1}};
        end
        wear_pkg::OFS_OPS1: nxt_s.ops1 = pwdata[17:0];
        wear_pkg::OFS_OPS2: nxt_s.ops2 = pwdata[17:0];
        wear_pkg::OFS_NOMINAL_BREAK_CURRENT: nxt_s.nominal_break_current = pwdata[13:0];
        wear_pkg::OFS_MAX_BREAK_CURRENT: nxt_s.max_break_current = pwdata[13:0];
        wear_pkg::OFS_SET1: nxt_s.set1 = pwdata[17:0];
        wear_pkg::OFS_SET2: nxt_s.set2 = pwdata[17:0];
        wear_pkg::OFS_INTMASK: nxt_s.intMask = pwdata[EV_BITS-1:0];
        default: nxt_s.left = nxt_s.left;
      endcase
    end

    // open command edge; a new one during a calculation is counted and raises the trigger event, but is not captured
    nxt_s.trigPrev = trig;
    if (trig & ~s_ff.trigPrev)
    begin
      nxt_s.brkCnt = nxt_s.brkCnt + 32'h0000_0001;
      evNew[wear_pkg::EV_TRIG] = 1'b1;
      if (s_ff.st == wear_pkg::ST_IDLE)
      begin
        nxt_s.cur = {phase_three_rms_current, phase_two_rms_current,
                     phase_one_rms_current};
        nxt_s.phase = 2'h0;
        nxt_s.st = wear_pkg::ST_LOAD;
      end
    end

    // deduction = 1 + (I-Nominal_break_current)(Ops1-Ops2) / (Ops2 (Max_break_current-Nominal_break_current)), linear in current
    unique case (s_ff.st)
      wear_pkg::ST_IDLE: nxt_s.bitCnt = '0;
      wear_pkg::ST_LOAD:
      begin
        nxt_s.quo = num;
        nxt_s.rem = '0;
        nxt_s.den = {14'h0000, s_ff.ops2} * {18'h0_0000, s_ff.max_break_current - s_ff.nominal_break_current};
        nxt_s.bitCnt = wear_pkg::DIV_BITS;
        nxt_s.st = wear_pkg::ST_DIV;
      end
      wear_pkg::ST_DIV:
      begin
        nxt_s.bitCnt = s_ff.bitCnt - 6'h01;
        if (s_ff.den == 32'h0000_0000)
        begin
          // degenerate characteristic: one operation per opening
          nxt_s.quo = '0;
          nxt_s.st = wear_pkg::ST_APPLY;
        end
        else
        begin
          if (shifted >= {1'b0, s_ff.den})
          begin
            nxt_s.rem = shifted - {1'b0, s_ff.den};
            nxt_s.quo = {s_ff.quo[30:0], 1'b1};
          end
          else
          begin
            nxt_s.rem = shifted;
            nxt_s.quo = {s_ff.quo[30:0], 1'b0};
          end
          if (s_ff.bitCnt == 6'h01)
            nxt_s.st = wear_pkg::ST_APPLY;
        end
      end
      wear_pkg::ST_APPLY:
      begin
        // saturates at zero rather than wrapping
        nxt_s.left[s_ff.phase] = (deduct >= 32'(nxt_s.left[s_ff.phase])) ? 18'h0_0000
          : 18'(32'(nxt_s.left[s_ff.phase]) - deduct);
        nxt_s.phase = s_ff.phase + 2'h1;
        nxt_s.st = (s_ff.phase == 2'h2) ? wear_pkg::ST_IDLE : wear_pkg::ST_LOAD;
      end
    endcase

    // alarms and their on/off events
    nxt_s.alarm1 = rawA1;
    nxt_s.alarm2 = rawA2;
    evNew[wear_pkg::EV_A1ON] = rawA1 & ~s_ff.alarm1;
    evNew[wear_pkg::EV_A1OFF] = ~rawA1 & s_ff.alarm1;
    evNew[wear_pkg::EV_A2ON] = rawA2 & ~s_ff.alarm2;
    evNew[wear_pkg::EV_A2OFF] = ~rawA2 & s_ff.alarm2;
    if (evNew[wear_pkg::EV_A1ON])
      nxt_s.a1Cnt = nxt_s.a1Cnt + 32'h0000_0001;
    if (evNew[wear_pkg::EV_A2ON])
      nxt_s.a2Cnt = nxt_s.a2Cnt + 32'h0000_0001;

    // one event per cycle, lowest code first; pending set wins over issue
    for (int e = EV_BITS - 1; e >= 0; e--)
      if (s_ff.evtPend[e])
      begin
        nxt_s.evtValid = 1'b1;
        nxt_s.evtCode = 3'(e);
      end
    if (nxt_s.evtValid)
      nxt_s.evtPend[nxt_s.evtCode] = 1'b0;
    nxt_s.evtPend = nxt_s.evtPend | evNew;
    nxt_s.evtStamp = s_ff.msCnt;

    // millisecond time base
    if (s_ff.msPre == 17'(MS_CYCLES - 1))
    begin
      nxt_s.msPre = '0;
      nxt_s.msCnt = s_ff.msCnt + 32'h0000_0001;
    end
    else
      nxt_s.msPre = s_ff.msPre + 17'h0_0001;

    // sticky status, cleared by reading it; a new event wins
    if (done & ~pwrite & (paddr == wear_pkg::OFS_INTSTAT))
      nxt_s.intStat = '0;
    nxt_s.intStat = nxt_s.intStat | evNew;
    nxt_s.irq = |(s_ff.intStat & s_ff.intMask);

    if (!rst_n)
    begin
      nxt_s = '0;
      nxt_s.st = wear_pkg::ST_IDLE;
      nxt_s.ops1 = wear_pkg::OPS1_DEF;
      nxt_s.ops2 = wear_pkg::OPS2_DEF;
      nxt_s.nominal_break_current = wear_pkg::NOMINAL_BREAK_CURRENT_DEF;
      nxt_s.max_break_current = wear_pkg::MAX_BREAK_CURRENT_DEF;
      nxt_s.set1 = wear_pkg::SET1_DEF;
      nxt_s.set2 = wear_pkg::SET2_DEF;
      nxt_s.left = {3{wear_pkg::OPS1_DEF}};
    end
  end

  always_ff @(posedge clk)
    s_ff <= nxt_s;

  assign pready = s_ff.pready;
  assign prdata = s_ff.prdata;
  assign pslverr = s_ff.pslverr;
  assign alarm1 = s_ff.alarm1;
  assign alarm2 = s_ff.alarm2;
  assign irq = s_ff.irq;
  assign evtValid = s_ff.evtValid;
  assign evtCode = s_ff.evtCode;
  assign evtStamp = s_ff.evtStamp;

  // ==========================================================
  // checks
  AST_A1_PICKUP: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_ff.forceEn && s_ff.a1En && below1) |=> alarm1) else $error("alarm 1 missed");
  AST_A1_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_ff.forceEn && !(s_ff.a1En && below1)) |=> !alarm1) else $error("alarm 1 stuck");
  AST_FORCE_A2: assert property (@(posedge clk) disable iff (!rst_n)
    (s_ff.forceEn && s_ff.forceVal == wear_pkg::COND_A2) |=> (alarm2 && !alarm1))
    else $error("force status ignored");
  AST_BRK_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    (trig && !s_ff.trigPrev && !(done && pwrite)) |=> s_ff.brkCnt == $past(s_ff.brkCnt) + 1)
    else $error("open count wrong");
  AST_CALC_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    (s_ff.st == wear_pkg::ST_LOAD && s_ff.phase == 2'h0) |-> ##[100:110]
    s_ff.st == wear_pkg::ST_IDLE) else $error("wear calculation length wrong");
  AST_LEFT_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
    !(done && pwrite) |=> s_ff.left[0] <= $past(s_ff.left[0])) else $error("count rose");
  AST_EVT_A1ON: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(alarm1) |-> ##[1:6] (evtValid && evtCode == 3'(wear_pkg::EV_A1ON)))
    else $error("alarm 1 on event missing");
  AST_APB_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready ##1 !pready) else $error("apb answer wrong");
  AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (done && pwrite && paddr == wear_pkg::OFS_CMD && pwdata[wear_pkg::CMD_RELOAD]
     && s_ff.st == wear_pkg::ST_IDLE) |=> s_ff.left[2] == s_ff.ops1)
    else $error("reload failed");
endmodule : breaker_wear_monitor
`default_nettype wire

//--- tb/breaker_source.sv
/*
  Partner model: relay contacts and phase RMS current source.
  Assumes the bench sets quietBit to the contact selected as trigger.
*/
`timescale 1ns/100ps
`default_nettype none
module breaker_source (
  input wire logic clk,
  output logic [7:0] relayOutputs,
  output logic [13:0] phase_one_rms_current,
  output logic [13:0] phase_two_rms_current,
  output logic [13:0] phase_three_rms_current
);
  logic [2:0] quietBit = 3'h0;
  logic noiseEn = 1'b0;
  logic openLvl = 1'b0;
  logic [7:0] sel;
  assign sel = 8'h01 << quietBit;
  initial
  begin
    relayOutputs = 8'h00;
    phase_one_rms_current = 14'h0000;
    phase_two_rms_current = 14'h0000;
    phase_three_rms_current = 14'h0000;
  end
  // other contacts chatter, so only the selected one may start a capture
  always @(posedge clk)
    relayOutputs <= (noiseEn ? 8'($urandom) & ~sel : 8'h00) | (openLvl ? sel : 8'h00);
  task automatic open_breaker(input logic [13:0] c1, input logic [13:0] c2,
                              input logic [13:0] c3);
    @(posedge clk);
    phase_one_rms_current <= c1;
    phase_two_rms_current <= c2;
    phase_three_rms_current <= c3;
    repeat (2) @(posedge clk);
    openLvl <= 1'b1;
    repeat (3) @(posedge clk);
    openLvl <= 1'b0;
    // next refresh lands after the capture, so stale capture shows up
    phase_one_rms_current <= 14'($urandom_range(600, 0));
    phase_two_rms_current <= 14'($urandom_range(600, 0));
    phase_three_rms_current <= 14'($urandom_range(600, 0));
  endtask : open_breaker
endmodule : breaker_source
`default_nettype wire

//--- tb/breaker_wear_monitor_tb.sv
/*
  Self-checking bench of the breaker wear monitor with an integer model.
  Assumes one clock, APB answered within 20 cycles, MS_CYCLES set to 10.
*/
`timescale 1ns/100ps
`default_nettype none
module breaker_wear_monitor_tb;
  localparam int MS = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, alarm1, alarm2, irq, evtValid, err;
  logic [31:0] prdata, evtStamp, rd;
  logic [2:0] evtCode;
  logic [7:0] relayOutputs;
  logic [13:0] cur1, cur2, cur3;
  logic [4:0] intExp = 5'h00;
  logic [4:0] maskV = 5'h12;
  logic m1 = 1'b0;
  logic m2 = 1'b0;
  logic en1 = 1'b0;
  logic en2 = 1'b0;
  logic [2:0] expQ[$];
  logic [2:0] seenQ[$];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int brk = 0;
  int a1c = 0;
  int a2c = 0;
  int left[3];
  int ops1, ops2, nominal_break_current, max_break_current, set1, set2;

  always #5 clk = ~clk;

  breaker_wear_monitor #(.MS_CYCLES(MS)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .relayOutputs(relayOutputs), .phase_one_rms_current(cur1),
    .phase_two_rms_current(cur2), .phase_three_rms_current(cur3),
    .alarm1(alarm1), .alarm2(alarm2), .irq(irq), .evtValid(evtValid),
    .evtCode(evtCode), .evtStamp(evtStamp));

  breaker_source partner_u (
    .clk(clk), .relayOutputs(relayOutputs), .phase_one_rms_current(cur1),
    .phase_two_rms_current(cur2), .phase_three_rms_current(cur3));

  // ==========
  // checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // stamp may lag issue by a cycle or two, hence the window of two ms
  always @(posedge clk)
  begin
    cyc <= rst_n ? cyc + 1 : 0;
    if (evtValid === 1'b1)
    begin
      seenQ.push_back(evtCode);
      check(32'(int'(evtStamp) * MS + 2 * MS > cyc && int'(evtStamp) * MS < cyc + 2 * MS), 1);
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdc

  // ==========
  // reference model
  function automatic void ev(input int code);
    expQ.push_back(3'(code));
    intExp[code] = 1'b1;
  endfunction : ev

  function automatic void model_alarm(input logic n1, input logic n2);
    if (n1 != m1)
      ev(n1 ? wear_pkg::EV_A1ON : wear_pkg::EV_A1OFF);
    if (n2 != m2)
      ev(n2 ? wear_pkg::EV_A2ON : wear_pkg::EV_A2OFF);
    a1c += int'(n1 && !m1);
    a2c += int'(n2 && !m2);
    m1 = n1;
    m2 = n2;
  endfunction : model_alarm

  function automatic void update();
    logic n1 = 1'b0;
    logic n2 = 1'b0;
    foreach (left[p])
    begin
      n1 |= left[p] < set1;
      n2 |= left[p] < set2;
    end
    model_alarm(n1 & en1, n2 & en2);
  endfunction : update

  task automatic status();
    repeat (6) @(posedge clk);
    check(32'(seenQ.size()), 32'(expQ.size()));
    foreach (expQ[i]) check(32'(seenQ[i]), 32'(expQ[i]));
    expQ.delete();
    seenQ.delete();
    rdc(wear_pkg::OFS_COND, m2 ? 32'h2 : {31'h0, m1});
    check(32'({alarm1, alarm2}), 32'({m1, m2}));
    check(32'(irq), 32'(|(intExp & maskV)));
  endtask : status

  task automatic trigger();
    int c[3];
    int ded;
    foreach (c[p]) c[p] = $urandom_range(600, 0);
    partner_u.open_breaker(14'(c[0]), 14'(c[1]), 14'(c[2]));
    brk++;
    ev(wear_pkg::EV_TRIG);
    apb(1'b0, wear_pkg::OFS_COND, 32'h0000_0000);
    for (int n = 0; n < 60 && rd[2] !== 1'b0; n++)
      apb(1'b0, wear_pkg::OFS_COND, 32'h0000_0000);
    // calculation never finished: count it and close the run
    if (rd[2] !== 1'b0)
    begin
      fail_count++;
      tally_and_finish();
    end
    foreach (c[p])
    begin
      c[p] = c[p] < nominal_break_current ? nominal_break_current : (c[p] > max_break_current ? max_break_current : c[p]);
      ded = 1 + (c[p] - nominal_break_current) * (ops1 - ops2) / (ops2 * (max_break_current - nominal_break_current));
      left[p] = left[p] > ded ? left[p] - ded : 0;
      rdc(wear_pkg::OFS_LEFT1 + 8'(4 * p), 32'(left[p]));
    end
    update();
    status();
  endtask : trigger

  initial
  begin
    int dv[17];
    int wv[6];
    void'($urandom(32'h4289));
    dv = '{0, 0, 50000, 100, 100, 2000, 1000, 100, 0, 0, 0, 0, 50000, 50000, 50000, 0, 0};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 17; i++) rdc(8'(4 * i), 32'(dv[i]));
    apb(1'b0, 8'h44, 32'h0000_0000);
    check(32'(err), 1);
    check(rd, 32'h0000_0000);
    ops1 = 1010;
    ops2 = 10;
    nominal_break_current = 100;
    max_break_current = 400;
    set1 = 1000;
    set2 = 100;
    wv = '{ops1, ops2, nominal_break_current, max_break_current, set1, set2};
    for (int i = 0; i < 6; i++) apb(1'b1, 8'(8 + 4 * i), 32'(wv[i]));
    apb(1'b1, wear_pkg::OFS_INTMASK, 32'(maskV));
    apb(1'b1, wear_pkg::OFS_CTRL, 32'h0000_0503);
    apb(1'b1, wear_pkg::OFS_CMD, 32'h0000_0002);
    en1 = 1'b1;
    en2 = 1'b1;
    left = '{ops1, ops1, ops1};
    partner_u.quietBit <= 3'h5;
    partner_u.noiseEn <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(8'(8 + 4 * i), 32'(wv[i]));
    status();
    repeat (14) trigger();
    apb(1'b1, wear_pkg::OFS_CTRL, 32'h0000_0500);
    en1 = 1'b0;
    en2 = 1'b0;
    update();
    status();
    apb(1'b1, wear_pkg::OFS_CTRL, 32'h0000_0503);
    en1 = 1'b1;
    en2 = 1'b1;
    update();
    status();
    apb(1'b1, wear_pkg::OFS_CMD, 32'h0000_0002);
    left = '{ops1, ops1, ops1};
    update();
    status();
    for (int v = 0; v < 5; v++)
    begin
      apb(1'b1, wear_pkg::OFS_CTRL, v < 4 ? 32'h0000_0504 | 32'(v << 3) : 32'h0000_0500);
      model_alarm(v == 1, v == 2);
      status();
    end
    rdc(wear_pkg::OFS_BRKCNT, 32'(brk));
    rdc(wear_pkg::OFS_A1CNT, 32'(a1c));
    rdc(wear_pkg::OFS_A2CNT, 32'(a2c));
    apb(1'b1, wear_pkg::OFS_CMD, 32'h0000_0001);
    for (int i = 9; i < 12; i++) rdc(8'(4 * i), 32'h0000_0000);
    rdc(wear_pkg::OFS_INTSTAT, 32'(intExp));
    intExp = 5'h00;
    repeat (3) @(posedge clk);
    check(32'(irq), 0);
    rdc(wear_pkg::OFS_INTSTAT, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : breaker_wear_monitor_tb
`default_nettype wire
